// ---- hw/laxu_load_unit.sv ----
`timescale 1ns/1ps
`include "laxu_cfg.svh"
// Contract
// - Word post-inc/dec loads use the old pointer, then step it by 4.
// - Short word load adds an unsigned 6-bit offset; pointer unchanged.
// - Long word load adds or subtracts a 17-bit magnitude offset.
// - Frame-relative word load uses frame pointer minus a 7-bit constant.
// - Pointer operand is any of six pointers, stack or frame pointer.
// - Pointer-step form loads from base, then adds step to base.
// - Same register as base and step gives a plain load, no update.
// - Index-modify load uses index, then index gets index plus modify.
// - Zero-extending half load clears the upper destination half.
// - Sign-extending half load copies bit 15 through the upper half.
// - Half-word loads take only pointer registers as address source.
// - Odd half-word address raises a misaligned access exception.
// - Half post-inc/dec loads use the old pointer, then step it by 2.
// - Short half load adds an unsigned even 5-bit offset, pointer kept.
// - Long half load adds or subtracts a 16-bit magnitude offset.
// - Large-offset forms are 32-bit encodings, all others 16-bit.
// - Only 16-bit encodings may issue in parallel; 32-bit ones rejected.
// - Word address not a multiple of four raises misaligned exception.
// - Index updates wrap circularly while the length register is nonzero; no top wrap if modify is negative.
module laxu_load_unit
    import laxu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire laxu_form_t issue_form,
    input wire logic issue_word,
    input wire logic issue_sext,
    input wire logic issue_long,
    input wire logic issue_parallel,
    input wire logic [2:0] issue_ptr,
    input wire logic [2:0] issue_step,
    input wire logic [1:0] issue_idx,
    input wire logic [1:0] issue_mod,
    input wire logic [16:0] issue_offset,
    input wire logic [2:0] issue_dst,
    output logic issue_ready,
    input wire logic rf_wr_en,
    input wire laxu_rclass_t rf_wr_class,
    input wire logic [2:0] rf_wr_sel,
    input wire logic [31:0] rf_wr_data,
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_half,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    output logic dreg_we,
    output logic [2:0] dreg_sel,
    output logic [31:0] dreg_data,
    output logic misalign_exc,
    output logic illegal_exc
);
    laxu_state_t state;
    logic [31:0] ptr_file [0:7];
    logic [31:0] idx_file [0:3];
    logic [31:0] mod_file [0:3];
    logic [31:0] len_file [0:3];
    logic [31:0] base_file [0:3];

    // Load in flight
    logic lat_half;
    logic lat_sext;
    logic lat_hi;
    logic [2:0] lat_dst;
    logic [2:0] lat_ptr;
    logic [1:0] lat_idx;
    logic [31:0] lat_new_ptr;
    logic lat_ptr_wr;
    logic [31:0] lat_new_idx;
    logic lat_idx_wr;

    logic launch;
    logic finish;
    logic is_long_form;
    logic is_idx_form;
    logic bad_form;
    logic [2:0] ptr_slot;
    logic [31:0] ext_data;

    laxu_agu_if agu ();

    laxu_addr_gen u_addr_gen (
        .bus(agu.gen)
    );

    laxu_extend u_extend (
        .half(lat_half),
        .sext(lat_sext),
        .hi_sel(lat_hi),
        .word_in(mem_rdata),
        .data_out(ext_data)
    );

    // Frame-relative form ignores the pointer field and always reads frame_ptr
    assign ptr_slot = (issue_form == LAXU_F_FRAME) ? `LAXU_FRAME_SLOT : issue_ptr;

    assign agu.form = issue_form;
    assign agu.is_word = issue_word;
    assign agu.same_reg = (issue_ptr == issue_step);
    assign agu.offset = issue_offset;
    assign agu.ptr_val = ptr_file[ptr_slot];
    assign agu.step_val = ptr_file[issue_step];
    assign agu.idx_val = idx_file[issue_idx];
    assign agu.mod_val = mod_file[issue_mod];
    assign agu.len_val = len_file[issue_idx];
    assign agu.base_val = base_file[issue_idx];

    assign is_long_form = (issue_form == LAXU_F_LONG_ADD) || (issue_form == LAXU_F_LONG_SUB);
    assign is_idx_form = (issue_form == LAXU_F_IMOD) || (issue_form == LAXU_F_IIND)
        || (issue_form == LAXU_F_IINC) || (issue_form == LAXU_F_IDEC);

    // Encoding checks come before alignment: a malformed load never reaches memory
    always_comb begin
        bad_form = 1'b0;
        if (!issue_word && is_idx_form) begin
            bad_form = 1'b1;
        end
        if (!issue_word && issue_form == LAXU_F_FRAME) begin
            bad_form = 1'b1;
        end
        if (issue_long != is_long_form) begin
            bad_form = 1'b1;
        end
        if (issue_long && issue_parallel) begin
            bad_form = 1'b1;
        end
        if (issue_form > LAXU_F_IDEC) begin
            bad_form = 1'b1;
        end
    end

    // Mode is not an input at all, so user and supervisor code see one behaviour
    assign launch = (state == LAXU_ST_IDLE) && issue_valid && !bad_form
        && !agu.misaligned;
    assign finish = (state == LAXU_ST_WAIT) && mem_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= LAXU_ST_IDLE;
        end else begin
            case (state)
                LAXU_ST_IDLE: begin
                    if (launch) begin
                        state <= LAXU_ST_WAIT;
                    end
                end
                LAXU_ST_WAIT: begin
                    if (mem_rvalid) begin
                        state <= LAXU_ST_IDLE;
                    end
                end
                default: begin
                    state <= LAXU_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            issue_ready <= 1'b1;
        end else if (launch) begin
            issue_ready <= 1'b0;
        end else if (finish) begin
            issue_ready <= 1'b1;
        end
    end

    // Memory request is a one-cycle strobe with the address held until the data returns
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
            mem_addr <= `LAXU_REG_RST;
            mem_half <= 1'b0;
        end else begin
            mem_req <= launch;
            if (launch) begin
                mem_addr <= agu.addr;
                mem_half <= !issue_word;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_half <= 1'b0;
            lat_sext <= 1'b0;
            lat_hi <= 1'b0;
            lat_dst <= `LAXU_SEL_RST;
            lat_ptr <= `LAXU_SEL_RST;
            lat_idx <= 2'b00;
            lat_new_ptr <= `LAXU_REG_RST;
            lat_ptr_wr <= 1'b0;
            lat_new_idx <= `LAXU_REG_RST;
            lat_idx_wr <= 1'b0;
        end else if (launch) begin
            lat_half <= !issue_word;
            lat_sext <= issue_sext;
            lat_hi <= agu.addr[1];
            lat_dst <= issue_dst;
            lat_ptr <= ptr_slot;
            lat_idx <= issue_idx;
            lat_new_ptr <= agu.new_ptr;
            lat_ptr_wr <= agu.ptr_wr;
            lat_new_idx <= agu.new_idx;
            lat_idx_wr <= agu.idx_wr;
        end
    end

    // Pointer writes from the core are taken only while idle; one in a load's launch cycle is lost if that load updates the same pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                ptr_file[i] <= `LAXU_REG_RST;
            end
        end else if (finish && lat_ptr_wr) begin
            ptr_file[lat_ptr] <= lat_new_ptr;
        end else if (rf_wr_en && issue_ready && rf_wr_class == LAXU_RC_PTR) begin
            ptr_file[rf_wr_sel] <= rf_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                idx_file[i] <= `LAXU_REG_RST;
            end
        end else if (finish && lat_idx_wr) begin
            idx_file[lat_idx] <= lat_new_idx;
        end else if (rf_wr_en && issue_ready && rf_wr_class == LAXU_RC_IDX) begin
            idx_file[rf_wr_sel[1:0]] <= rf_wr_data;
        end
    end

    // Modify, length and base change only by explicit write; a load never touches them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mod_file[i] <= `LAXU_REG_RST;
                len_file[i] <= `LAXU_REG_RST;
                base_file[i] <= `LAXU_REG_RST;
            end
        end else if (rf_wr_en && issue_ready) begin
            case (rf_wr_class)
                LAXU_RC_MOD: begin
                    mod_file[rf_wr_sel[1:0]] <= rf_wr_data;
                end
                LAXU_RC_LEN: begin
                    len_file[rf_wr_sel[1:0]] <= rf_wr_data;
                end
                LAXU_RC_BASE: begin
                    base_file[rf_wr_sel[1:0]] <= rf_wr_data;
                end
                default: begin
                    len_file[0] <= len_file[0];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dreg_we <= 1'b0;
            dreg_sel <= `LAXU_SEL_RST;
            dreg_data <= `LAXU_REG_RST;
        end else begin
            dreg_we <= finish;
            if (finish) begin
                dreg_sel <= lat_dst;
                dreg_data <= ext_data;
            end
        end
    end

    // Exceptions are one-cycle pulses; the offending load is dropped whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            misalign_exc <= 1'b0;
            illegal_exc <= 1'b0;
        end else begin
            illegal_exc <= (state == LAXU_ST_IDLE) && issue_valid && bad_form;
            misalign_exc <= (state == LAXU_ST_IDLE) && issue_valid && !bad_form
                && agu.misaligned;
        end
    end
endmodule : laxu_load_unit

// ---- hw/laxu_cfg.svh ----
`ifndef LAXU_CFG_SVH
`define LAXU_CFG_SVH
// Pointer steps in bytes
`define LAXU_WORD_STEP 32'h0000_0004
`define LAXU_HALF_STEP 32'h0000_0002
// Offset field widths
`define LAXU_SHORT_WORD_W 6
`define LAXU_FRAME_W 7
`define LAXU_LONG_WORD_W 17
`define LAXU_SHORT_HALF_W 5
`define LAXU_LONG_HALF_W 16
// Pointer file slots for the stack and frame pointers
`define LAXU_STACK_SLOT 3'h6
`define LAXU_FRAME_SLOT 3'h7
// Reset values
`define LAXU_REG_RST 32'h0000_0000
`define LAXU_SEL_RST 3'h0
`endif

// ---- hw/laxu_pkg.sv ----
package laxu_pkg;
    typedef enum logic [3:0] {
        LAXU_F_IND = 4'b0000,
        LAXU_F_INC = 4'b0001,
        LAXU_F_DEC = 4'b0010,
        LAXU_F_SHORT = 4'b0011,
        LAXU_F_LONG_ADD = 4'b0100,
        LAXU_F_LONG_SUB = 4'b0101,
        LAXU_F_FRAME = 4'b0110,
        LAXU_F_PSTEP = 4'b0111,
        LAXU_F_IMOD = 4'b1000,
        LAXU_F_IIND = 4'b1001,
        LAXU_F_IINC = 4'b1010,
        LAXU_F_IDEC = 4'b1011
    } laxu_form_t;
    typedef enum logic [2:0] {
        LAXU_RC_PTR = 3'b000,
        LAXU_RC_IDX = 3'b001,
        LAXU_RC_MOD = 3'b010,
        LAXU_RC_LEN = 3'b011,
        LAXU_RC_BASE = 3'b100
    } laxu_rclass_t;
    typedef enum logic [1:0] {
        LAXU_ST_IDLE = 2'b00,
        LAXU_ST_WAIT = 2'b01
    } laxu_state_t;
endpackage : laxu_pkg

// ---- hw/laxu_agu_if.sv ----
`timescale 1ns/1ps
interface laxu_agu_if;
    import laxu_pkg::*;
    laxu_form_t form;
    logic is_word;
    logic same_reg;
    logic [16:0] offset;
    logic [31:0] ptr_val;
    logic [31:0] step_val;
    logic [31:0] idx_val;
    logic [31:0] mod_val;
    logic [31:0] len_val;
    logic [31:0] base_val;
    logic [31:0] addr;
    logic [31:0] new_ptr;
    logic ptr_wr;
    logic [31:0] new_idx;
    logic idx_wr;
    logic misaligned;
    modport gen (input form, is_word, same_reg, offset, ptr_val, step_val, idx_val,
        mod_val, len_val, base_val, output addr, new_ptr, ptr_wr, new_idx, idx_wr,
        misaligned);
    modport top (output form, is_word, same_reg, offset, ptr_val, step_val, idx_val,
        mod_val, len_val, base_val, input addr, new_ptr, ptr_wr, new_idx, idx_wr,
        misaligned);
endinterface : laxu_agu_if

// ---- hw/laxu_addr_gen.sv ----
`timescale 1ns/1ps
`include "laxu_cfg.svh"
module laxu_addr_gen
    import laxu_pkg::*;
(
    laxu_agu_if.gen bus
);
    logic [31:0] step;
    logic [31:0] sum;
    logic [31:0] lim;

    always_comb begin
        step = bus.is_word ? `LAXU_WORD_STEP : `LAXU_HALF_STEP;
        bus.addr = bus.ptr_val;
        bus.new_ptr = bus.ptr_val;
        bus.ptr_wr = 1'b0;
        bus.new_idx = bus.idx_val;
        bus.idx_wr = 1'b0;
        sum = bus.idx_val;
        lim = bus.base_val + bus.len_val;
        case (bus.form)
            LAXU_F_INC: begin
                bus.new_ptr = bus.ptr_val + step;
                bus.ptr_wr = 1'b1;
            end
            LAXU_F_DEC: begin
                bus.new_ptr = bus.ptr_val - step;
                bus.ptr_wr = 1'b1;
            end
            LAXU_F_SHORT: begin
                if (bus.is_word) begin
                    bus.addr = bus.ptr_val + {{(32-`LAXU_SHORT_WORD_W){1'b0}},
                        bus.offset[`LAXU_SHORT_WORD_W-1:0]};
                end else begin
                    bus.addr = bus.ptr_val + {{(32-`LAXU_SHORT_HALF_W){1'b0}},
                        bus.offset[`LAXU_SHORT_HALF_W-1:0]};
                end
            end
            LAXU_F_LONG_ADD, LAXU_F_LONG_SUB: begin
                if (bus.is_word) begin
                    sum = {{(32-`LAXU_LONG_WORD_W){1'b0}},
                        bus.offset[`LAXU_LONG_WORD_W-1:0]};
                end else begin
                    sum = {{(32-`LAXU_LONG_HALF_W){1'b0}},
                        bus.offset[`LAXU_LONG_HALF_W-1:0]};
                end
                bus.addr = (bus.form == LAXU_F_LONG_SUB) ? bus.ptr_val - sum
                    : bus.ptr_val + sum;
            end
            LAXU_F_FRAME: begin
                bus.addr = bus.ptr_val - {{(32-`LAXU_FRAME_W){1'b0}},
                    bus.offset[`LAXU_FRAME_W-1:0]};
            end
            LAXU_F_PSTEP: begin
                bus.new_ptr = bus.ptr_val + bus.step_val;
                bus.ptr_wr = !bus.same_reg;
            end
            LAXU_F_IMOD, LAXU_F_IINC, LAXU_F_IDEC: begin
                bus.addr = bus.idx_val;
                if (bus.form == LAXU_F_IMOD) begin
                    sum = bus.idx_val + bus.mod_val;
                end else if (bus.form == LAXU_F_IINC) begin
                    sum = bus.idx_val + step;
                end else begin
                    sum = bus.idx_val - step;
                end
                bus.new_idx = sum;
                // Wrap only while the length is nonzero; zero length gives linear steps
                if (bus.len_val != `LAXU_REG_RST) begin
                    if (!sum[31] && bus.form != LAXU_F_IDEC && !bus.mod_val[31]
                        && sum >= lim) begin
                        bus.new_idx = sum - bus.len_val;
                    end else if (sum < bus.base_val) begin
                        bus.new_idx = sum + bus.len_val;
                    end
                end
                bus.idx_wr = 1'b1;
            end
            LAXU_F_IIND: begin
                bus.addr = bus.idx_val;
            end
            default: begin
                bus.addr = bus.ptr_val;
            end
        endcase
        bus.misaligned = bus.is_word ? (bus.addr[1:0] != 2'b00) : bus.addr[0];
    end
endmodule : laxu_addr_gen

// ---- hw/laxu_extend.sv ----
`timescale 1ns/1ps
module laxu_extend (
    input wire logic half,
    input wire logic sext,
    input wire logic hi_sel,
    input wire logic [31:0] word_in,
    output logic [31:0] data_out
);
    logic [15:0] hw;

    always_comb begin
        hw = hi_sel ? word_in[31:16] : word_in[15:0];
        if (!half) begin
            data_out = word_in;
        end else if (sext) begin
            data_out = {{16{hw[15]}}, hw};
        end else begin
            data_out = {16'h0000, hw};
        end
    end
endmodule : laxu_extend

// ---- tb/laxu_load_unit_assertions.sv ----
`timescale 1ns/1ps
module laxu_load_unit_chk
    import laxu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire laxu_form_t issue_form,
    input wire logic issue_word,
    input wire logic issue_sext,
    input wire logic issue_long,
    input wire logic issue_parallel,
    input wire logic issue_ready,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_half,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    input wire logic dreg_we,
    input wire logic [31:0] dreg_data,
    input wire logic misalign_exc,
    input wire logic illegal_exc
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic sext_q;
    logic [31:0] rd_q;
    assign acc = issue_valid && issue_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sext_q <= 1'b0;
        end else if (acc) begin
            sext_q <= issue_sext;
        end
    end
    // Keep the returned word so the write one cycle later can be tied to it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 32'h0000_0000;
        end else if (mem_rvalid && !issue_ready) begin
            rd_q <= mem_rdata;
        end
    end
    AST_ONE_ANSWER: assert property (acc |=> $onehot({mem_req, misalign_exc, illegal_exc}))
        else $error("issue without exactly one answer");
    AST_LONG_PAR: assert property (acc && issue_long && issue_parallel |=> illegal_exc)
        else $error("parallel long encoding accepted");
    AST_LONG_FORM: assert property (acc && issue_long != (issue_form inside {LAXU_F_LONG_ADD,
        LAXU_F_LONG_SUB}) |=> illegal_exc)
        else $error("encoding length not checked");
    AST_HALF_SRC: assert property (acc && !issue_word && (issue_form >= LAXU_F_IMOD ||
        issue_form == LAXU_F_FRAME) |=> illegal_exc)
        else $error("half load through index accepted");
    AST_ALIGN: assert property (mem_req |-> (mem_half ? !mem_addr[0] : mem_addr[1:0] == 2'b00))
        else $error("misaligned request sent");
    AST_DONE: assert property (!issue_ready && mem_rvalid |=> dreg_we && issue_ready)
        else $error("no completion after data");
    AST_WAIT: assert property (!issue_ready && !mem_rvalid |=> !issue_ready && !dreg_we)
        else $error("completion without data");
    AST_ZERO_EXT: assert property (dreg_we && mem_half && !sext_q |-> dreg_data[31:16] == 16'h0000)
        else $error("upper half not cleared");
    AST_SIGN_EXT: assert property (dreg_we && mem_half && sext_q |->
        dreg_data[31:16] == {16{dreg_data[15]}})
        else $error("upper half not sign filled");
    AST_HALF_DATA: assert property (dreg_we && mem_half |->
        dreg_data[15:0] == (mem_addr[1] ? rd_q[31:16] : rd_q[15:0]))
        else $error("wrong half selected");
    AST_WORD_DATA: assert property (dreg_we && !mem_half |-> dreg_data == rd_q)
        else $error("word data altered");
endmodule : laxu_load_unit_chk

bind laxu_load_unit laxu_load_unit_chk i_chk (.clk, .rst_n, .issue_valid, .issue_form,
    .issue_word, .issue_sext, .issue_long, .issue_parallel, .issue_ready, .mem_req, .mem_addr,
    .mem_half, .mem_rvalid, .mem_rdata, .dreg_we, .dreg_data, .misalign_exc, .illegal_exc);

// ---- tb/laxu_mem_model.sv ----
`timescale 1ns/1ps
module laxu_mem_model (
    input wire logic clk,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    int cnt = -1;
    initial begin
        mem_rvalid = 1'b0;
        mem_rdata = 32'h0000_0000;
    end
    // Data lines carry noise outside the answer cycle; delay 0 answers inside the request cycle
    always @(negedge clk) begin
        if (mem_req === 1'b1) cnt = $urandom_range(3, 0);
        mem_rvalid <= (cnt == 0);
        mem_rdata <= (cnt == 0) ? {~mem_addr[15:0], mem_addr[15:2], 2'b00} : $urandom;
        if (cnt >= 0) cnt--;
    end
endmodule : laxu_mem_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import laxu_pkg::*;
    typedef struct {int k; logic [31:0] v; logic h; logic [2:0] s;} laxu_note_t;
    logic clk = 0, rst_n = 0, issue_valid = 0, issue_word = 0, issue_sext = 0;
    logic issue_long = 0, issue_parallel = 0, rf_wr_en = 0;
    laxu_form_t issue_form = LAXU_F_IND;
    laxu_rclass_t rf_wr_class = LAXU_RC_PTR;
    logic [2:0] issue_ptr = 0, issue_step = 0, issue_dst = 0, rf_wr_sel = 0, dreg_sel;
    logic [1:0] issue_idx = 0, issue_mod = 0;
    logic [16:0] issue_offset = 0;
    logic [31:0] rf_wr_data = 0, mem_addr, mem_rdata, dreg_data;
    logic issue_ready, mem_req, mem_half, mem_rvalid, dreg_we, misalign_exc, illegal_exc;
    logic [31:0] p [8], ix [4], md [4], ln [4], bs [4];
    laxu_note_t q [$];
    int n_mismatch = 0, checks = 0, cyc = 0;
    laxu_load_unit i_dut (.clk, .rst_n, .issue_valid, .issue_form, .issue_word, .issue_sext,
        .issue_long, .issue_parallel, .issue_ptr, .issue_step, .issue_idx, .issue_mod,
        .issue_offset, .issue_dst, .issue_ready, .rf_wr_en, .rf_wr_class, .rf_wr_sel,
        .rf_wr_data, .mem_req, .mem_addr, .mem_half, .mem_rvalid, .mem_rdata, .dreg_we,
        .dreg_sel, .dreg_data, .misalign_exc, .illegal_exc);
    laxu_mem_model i_mem (.clk, .mem_req, .mem_addr, .mem_rvalid, .mem_rdata);
    task automatic bad(string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : bad
    task automatic summarize;
        if (q.size() != 0) bad("result missing");
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic take(output laxu_note_t n);
        checks++;
        n = '{-1, 0, 0, 0};
        if (q.size() != 0) n = q.pop_front();
    endtask : take
    task automatic cmp_mem;
        laxu_note_t n;
        take(n);
        if (n.k != 0 || n.v !== mem_addr || n.h !== mem_half) bad("memory request");
    endtask : cmp_mem
    task automatic cmp_dreg;
        laxu_note_t n;
        take(n);
        if (n.k != 1 || n.v !== dreg_data || n.s !== dreg_sel) bad("destination write");
    endtask : cmp_dreg
    task automatic cmp_exc(int k);
        laxu_note_t n;
        take(n);
        if (n.k != k) bad("exception");
    endtask : cmp_exc
    // Leaves the write strobe up so back-to-back writes never toggle it in one step
    task automatic wr(laxu_rclass_t c, int s, logic [31:0] d);
        rf_wr_en = 1;
        rf_wr_class = c;
        rf_wr_sel = 3'(s);
        rf_wr_data = d;
        case (c)
            LAXU_RC_PTR: p[s] = d;
            LAXU_RC_IDX: ix[s] = d;
            LAXU_RC_MOD: md[s] = d;
            LAXU_RC_LEN: ln[s] = d;
            default: bs[s] = d;
        endcase
        @(negedge clk);
    endtask : wr
    task automatic ld(logic [3:0] f, logic w, s, lg, pr, logic [2:0] pt, st,
        logic [1:0] i, m, logic [16:0] o);
        logic [31:0] a, nv, wd;
        logic [15:0] h;
        logic xf, ill;
        logic [2:0] d;
        d = 3'($urandom_range(7, 0));
        xf = f >= 4'h8;
        a = xf ? ix[i] : (f == 4'h6 ? p[7] : p[pt]);
        nv = a;
        case (f)
            4'h1, 4'hA: nv = a + (w ? 32'h0000_0004 : 32'h0000_0002);
            4'h2, 4'hB: nv = a - (w ? 32'h0000_0004 : 32'h0000_0002);
            4'h3: a = a + (w ? 32'(o[5:0]) : 32'(o[4:0]));
            4'h4: a = a + (w ? 32'(o) : 32'(o[15:0]));
            4'h5: a = a - (w ? 32'(o) : 32'(o[15:0]));
            4'h6: a = a - 32'(o[6:0]);
            4'h7: nv = pt == st ? a : a + p[st];
            4'h8: nv = a + md[m];
            default: ;
        endcase
        if (xf && f != 4'h9 && ln[i] != 0) begin
            if (nv >= bs[i] + ln[i]) nv = nv - ln[i];
            else if (nv < bs[i]) nv = nv + ln[i];
        end
        wd = {~a[15:0], a[15:2], 2'b00};
        h = a[1] ? wd[31:16] : wd[15:0];
        ill = f > 4'hB || lg != (f == 4'h4 || f == 4'h5) || (lg && pr);
        if (ill || (!w && (xf || f == 4'h6))) q.push_back('{3, 0, 0, 0});
        else if (w ? a[1:0] != 2'b00 : a[0]) q.push_back('{2, 0, 0, 0});
        else begin
            q.push_back('{0, a, !w, 0});
            q.push_back('{1, w ? wd : {s ? {16{h[15]}} : 16'h0000, h}, 0, d});
            if (xf) ix[i] = nv;
            else if (f inside {4'h1, 4'h2, 4'h7}) p[pt] = nv;
        end
        issue_valid = 1;
        issue_form = laxu_form_t'(f);
        issue_word = w;
        issue_sext = s;
        issue_long = lg;
        issue_parallel = pr;
        issue_ptr = pt;
        issue_step = st;
        issue_idx = i;
        issue_mod = m;
        issue_offset = o;
        issue_dst = d;
        @(negedge clk);
        issue_valid = 0;
        @(negedge clk);
        for (int c = 0; c < 9 && issue_ready !== 1'b1; c++) @(negedge clk);
    endtask : ld
    always @(negedge clk) begin
        if (mem_req !== 1'b0) cmp_mem;
        if (dreg_we !== 1'b0) cmp_dreg;
        if (misalign_exc !== 1'b0) cmp_exc(2);
        if (illegal_exc !== 1'b0) cmp_exc(3);
    end
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad("timeout");
            summarize;
        end
    end
    initial begin
        logic [3:0] f;
        logic w, lg;
        logic [16:0] o;
        void'($urandom(32'hfc1a_4245));
        repeat (8) @(negedge clk);
        rst_n = 1;
        for (int r = 0; r < 8; r++) wr(LAXU_RC_PTR, r, 32'h0004_0000 + ($urandom & 32'h0000_fffc));
        for (int r = 0; r < 4; r++) begin
            wr(LAXU_RC_BASE, r, 32'h0002_0000 * (r + 1));
            wr(LAXU_RC_LEN, r, r[0] ? 32'h0000_0040 : 32'h0000_0000);
            wr(LAXU_RC_IDX, r, bs[r] + 32'h0000_0008);
            wr(LAXU_RC_MOD, r, r == 3 ? 32'hffff_fff8 : 32'(4 * r + 4));
        end
        rf_wr_en = 0;
        for (int t = 0; t < 400; t++) begin
            f = t % 40 == 0 ? 4'(12 + t / 40 % 4) : 4'($urandom_range(11, 0));
            w = f >= 4'h8 ? $urandom_range(9, 0) != 0 : 1'($urandom_range(1, 0));
            lg = f == 4'h4 || f == 4'h5;
            if ($urandom_range(19, 0) == 0) lg = !lg;
            o = 17'($urandom);
            if ($urandom_range(3, 0) != 0) o[1:0] = 2'b00;
            ld(f, w, 1'($urandom_range(1, 0)), lg, $urandom_range(3, 0) == 0,
                3'($urandom_range(7, 0)), 3'($urandom_range(7, 0)), 2'($urandom_range(3, 0)),
                2'($urandom_range(3, 0)), o);
        end
        for (int r = 0; r < 8; r++) ld(4'h0, 0, 0, 0, 0, 3'(r), 0, 0, 0, 0);
        for (int r = 0; r < 4; r++) ld(4'h9, 1, 0, 0, 0, 0, 0, 2'(r), 0, 0);
        repeat (2) @(negedge clk);
        summarize;
    end
endmodule : testbench
